// ### src/dtc_counter.sv
// Increment helper for one 8-bit count byte with carry
`timescale 1ns/1ps
module dtc_counter (
    input wire logic [7:0] val,
    input wire logic [7:0] mask,
    output logic [7:0] nxt,
    output logic carry
);
    import dtc_pkg::*;
    logic [8:0] sum;
    always_comb begin
        sum = {1'b0, val & mask} + 9'h001;
        nxt = sum[7:0];
        carry = ((val & mask) == mask);
    end
endmodule

// ### src/dtc_mc_gen.sv
// Machine cycle strobe generator and count input edge sampler
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_mc_gen (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin_in,
    output logic mc_tick,
    output logic fall_seen
);
    import dtc_pkg::*;
    logic [`DTC_MC_CNT_W-1:0] div_q;
    logic sync1_q;
    logic sync2_q;
    logic samp_q;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst || div_q == `DTC_MC_CNT_W'(`DTC_CPU_CLOCKS_PER_MC - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + `DTC_MC_CNT_W'(1);
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            mc_tick <= 1'b0;
        end else begin
            mc_tick <= (div_q == `DTC_MC_CNT_W'(`DTC_CPU_CLOCKS_PER_MC - 1));
        end
    end
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
    end
    // One sample per machine cycle; a fall is high then low
    always_ff @(posedge mclk) begin
        if (rst) begin
            samp_q <= 1'b1;
            fall_seen <= 1'b0;
        end else if (div_q == `DTC_MC_CNT_W'(`DTC_CPU_CLOCKS_PER_MC - 1)) begin
            samp_q <= sync2_q;
            fall_seen <= samp_q & ~sync2_q;
        end
    end
endmodule

// ### src/dtc_params.svh
// Field positions, widths, reset values and timing counts of the timer unit
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_CPU_CLOCKS_PER_MC 6
`define DTC_MC_CNT_W 3
`define DTC_MODE_W 8
`define DTC_MODE_RESET 8'h00
`define DTC_CTRL_RESET 8'h00
`define DTC_MODE_T0_LO 0
`define DTC_MODE_T0_HI 1
`define DTC_MODE_T0_CT 2
`define DTC_MODE_T0_GATE 3
`define DTC_MODE_T1_LO 4
`define DTC_MODE_T1_HI 5
`define DTC_CTRL_RUN0 4
`define DTC_CTRL_OVF0 5
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_OVF1 7
`define DTC_BYTE_RESET 8'h00
`define DTC_M0_LOW_MASK 8'h1F
`endif

// ### src/dtc_pkg.sv
// Types shared by the timer unit
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE13,
        DTC_MODE16,
        DTC_MODE8R,
        DTC_MODESPLIT
    } dtc_mode_t;
    typedef logic [7:0] dtc_byte_t;
endpackage

// ### src/dtc_top.sv
// Dual timer/counter unit with overflow toggle output
//
// Functional notes
// - Timer function counts once per machine cycle of six clocks.
// - Counter function samples count pin each machine cycle, counts falls.
// - New count shows in cycle after fall detection.
// - Counter-select bit picks timer or event counting for timer zero.
// - Two mode bits pick one of four modes per timer.
// - Mode zero is 13-bit: high byte plus low five bits.
// - Rollover to zero sets the timer overflow flag.
// - Timer zero runs when run bit set and gate clear or pin high.
// - Setting run bit never alters count bytes.
// - Mode one uses all sixteen bits.
// - Mode two low byte overflows and reloads from high byte.
// - Timer one in mode three halts as if run bit clear.
// - Split mode low byte uses timer zero controls and pin.
// - Split mode high byte counts cycles, uses timer one run and flag.
// - Split mode timer one runs outside its mode three, no flag.
// - Option inverts count pin on each timer zero overflow; an overflow in the first cycle of the option only drives the pin high.
// - Port two mode bit enables toggle; pin starts high.
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] timer_mode_reg,
    input wire logic run_bit_zero,
    input wire logic run_bit_one,
    input wire logic ovf_clr_zero,
    input wire logic ovf_clr_one,
    input wire logic toggle_out_enable,
    input wire logic ext_irq_zero_pin,
    input wire logic count_in_pin_zero_i,
    input wire logic wr_high_zero,
    input wire logic wr_low_zero,
    input wire logic wr_high_one,
    input wire logic wr_low_one,
    input wire dtc_pkg::dtc_byte_t wr_data,
    output dtc_pkg::dtc_byte_t count_high_byte_zero,
    output dtc_pkg::dtc_byte_t count_low_byte_zero,
    output dtc_pkg::dtc_byte_t count_high_byte_one,
    output dtc_pkg::dtc_byte_t count_low_byte_one,
    output logic overflow_flag_zero,
    output logic overflow_flag_one,
    output logic count_in_pin_zero_o,
    output logic count_in_pin_zero_oe
);
    import dtc_pkg::*;

    function automatic dtc_mode_t mode_of(input logic hi, input logic lo);
        mode_of = dtc_mode_t'({hi, lo});
    endfunction

    logic mc_tick;
    logic fall_seen;
    logic gate_sync1_q;
    logic gate_sync2_q;
    dtc_mode_t mode0;
    dtc_mode_t mode1;
    logic ev0;
    logic run0;
    logic run1;
    logic inc0;
    logic inc_h0;
    logic inc1;
    logic [7:0] low_mask0;
    logic [7:0] low_mask1;
    logic [7:0] l0_n;
    logic [7:0] h0_n;
    logic [7:0] l1_n;
    logic [7:0] h1_n;
    logic l0_c;
    logic h0_c;
    logic l1_c;
    logic h1_c;
    logic ovf0;
    logic ovf1;
    logic ovf_h0;
    logic tog_en_q;

    ////////////////////////////////////////////////////////////////
    dtc_mc_gen u_mc (
        .mclk(mclk),
        .rst(rst),
        .pin_in(count_in_pin_zero_i),
        .mc_tick(mc_tick),
        .fall_seen(fall_seen)
    );

    always_ff @(posedge mclk) begin
        gate_sync1_q <= ext_irq_zero_pin;
        gate_sync2_q <= gate_sync1_q;
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        mode0 = mode_of(timer_mode_reg[`DTC_MODE_T0_HI], timer_mode_reg[`DTC_MODE_T0_LO]);
        mode1 = mode_of(timer_mode_reg[`DTC_MODE_T1_HI], timer_mode_reg[`DTC_MODE_T1_LO]);
        // Fall is flagged at the detection point together with mc_tick, so count lands next cycle
        ev0 = timer_mode_reg[`DTC_MODE_T0_CT] ? fall_seen : 1'b1;
        run0 = run_bit_zero
            & (~timer_mode_reg[`DTC_MODE_T0_GATE] | gate_sync2_q);
        inc0 = mc_tick & run0 & ev0;
        inc_h0 = mc_tick & run_bit_one & (mode0 == DTC_MODESPLIT);
        // Timer one borrows its run bit only when not split
        run1 = (mode1 != DTC_MODESPLIT)
            & ((mode0 == DTC_MODESPLIT) | run_bit_one);
        inc1 = mc_tick & run1;
        low_mask0 = (mode0 == DTC_MODE13) ? `DTC_M0_LOW_MASK : 8'hFF;
        low_mask1 = (mode1 == DTC_MODE13) ? `DTC_M0_LOW_MASK : 8'hFF;
    end

    dtc_counter u_l0 (.val(count_low_byte_zero), .mask(low_mask0), .nxt(l0_n), .carry(l0_c));
    dtc_counter u_h0 (.val(count_high_byte_zero), .mask(8'hFF), .nxt(h0_n), .carry(h0_c));
    dtc_counter u_l1 (.val(count_low_byte_one), .mask(low_mask1), .nxt(l1_n), .carry(l1_c));
    dtc_counter u_h1 (.val(count_high_byte_one), .mask(8'hFF), .nxt(h1_n), .carry(h1_c));

    always_comb begin
        unique case (mode0)
            DTC_MODE13, DTC_MODE16: ovf0 = inc0 & l0_c & h0_c;
            DTC_MODE8R, DTC_MODESPLIT: ovf0 = inc0 & l0_c;
        endcase
        unique case (mode1)
            DTC_MODE13, DTC_MODE16: ovf1 = inc1 & l1_c & h1_c;
            DTC_MODE8R: ovf1 = inc1 & l1_c;
            DTC_MODESPLIT: ovf1 = 1'b0;
        endcase
        ovf_h0 = inc_h0 & h0_c;
    end

    ////////////////////////////////////////////////////////////////
    // Software write wins over a same-cycle increment; run bit touches no byte
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_low_byte_zero <= `DTC_BYTE_RESET;
        end else if (wr_low_zero) begin
            count_low_byte_zero <= wr_data;
        end else if (inc0) begin
            if (mode0 == DTC_MODE8R && l0_c) begin
                count_low_byte_zero <= count_high_byte_zero;
            end else begin
                count_low_byte_zero <= l0_n;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count_high_byte_zero <= `DTC_BYTE_RESET;
        end else if (wr_high_zero) begin
            count_high_byte_zero <= wr_data;
        end else if (mode0 == DTC_MODESPLIT) begin
            if (inc_h0) begin
                count_high_byte_zero <= h0_n;
            end
        end else if (inc0 && l0_c && (mode0 != DTC_MODE8R)) begin
            count_high_byte_zero <= h0_n;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count_low_byte_one <= `DTC_BYTE_RESET;
        end else if (wr_low_one) begin
            count_low_byte_one <= wr_data;
        end else if (inc1) begin
            if (mode1 == DTC_MODE8R && l1_c) begin
                count_low_byte_one <= count_high_byte_one;
            end else begin
                count_low_byte_one <= l1_n;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count_high_byte_one <= `DTC_BYTE_RESET;
        end else if (wr_high_one) begin
            count_high_byte_one <= wr_data;
        end else if (inc1 && l1_c && (mode1 != DTC_MODE8R)) begin
            count_high_byte_one <= h1_n;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Set beats clear so an overflow in the clearing cycle survives
    always_ff @(posedge mclk) begin
        if (rst) begin
            overflow_flag_zero <= 1'b0;
        end else if (ovf0) begin
            overflow_flag_zero <= 1'b1;
        end else if (ovf_clr_zero) begin
            overflow_flag_zero <= 1'b0;
        end
    end

    // In split mode the high byte of timer zero owns this flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            overflow_flag_one <= 1'b0;
        end else if ((mode0 == DTC_MODESPLIT) ? ovf_h0 : ovf1) begin
            overflow_flag_one <= 1'b1;
        end else if (ovf_clr_one) begin
            overflow_flag_one <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            tog_en_q <= 1'b0;
            count_in_pin_zero_o <= 1'b1;
            count_in_pin_zero_oe <= 1'b0;
        end else begin
            tog_en_q <= toggle_out_enable;
            count_in_pin_zero_oe <= toggle_out_enable;
            if (toggle_out_enable && !tog_en_q) begin
                count_in_pin_zero_o <= 1'b1;
            end else if (toggle_out_enable && ovf0) begin
                count_in_pin_zero_o <= ~count_in_pin_zero_o;
            end
        end
    end
endmodule

// ### verification/dtc_pin_src.sv
// Far-side model: event source on the count pin and the gate pin
`timescale 1ns/1ps
module dtc_pin_src (
    input wire logic mclk,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_lvl,
    output logic gate
);
    logic ev_q = 1'b1;
    initial gate = 1'b0;
    // Pulled-up pin, the unit's own drive wins while enabled
    assign pin_lvl = pin_oe ? pin_o : ev_q;
    task automatic set_gate(input logic v);
        @(negedge mclk);
        gate = v;
    endtask
    task automatic falls(input int n);
        repeat (n) begin
            @(negedge mclk);
            ev_q = 1'b0;
            repeat (8) @(negedge mclk);
            ev_q = 1'b1;
            repeat (8) @(negedge mclk);
        end
    endtask
endmodule

// ### verification/dtc_properties.sv
// Port-level checks for the dual timer unit
`timescale 1ns/1ps
module dtc_properties
    import dtc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] timer_mode_reg,
    input wire logic run_bit_zero,
    input wire logic ovf_clr_zero,
    input wire logic ovf_clr_one,
    input wire logic toggle_out_enable,
    input wire logic wr_high_zero,
    input wire logic wr_low_zero,
    input wire logic wr_high_one,
    input wire logic wr_low_one,
    input wire dtc_pkg::dtc_byte_t wr_data,
    input wire dtc_pkg::dtc_byte_t count_high_byte_zero,
    input wire dtc_pkg::dtc_byte_t count_low_byte_zero,
    input wire dtc_pkg::dtc_byte_t count_high_byte_one,
    input wire dtc_pkg::dtc_byte_t count_low_byte_one,
    input wire logic overflow_flag_zero,
    input wire logic overflow_flag_one,
    input wire logic count_in_pin_zero_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Stopped and untouched: nothing may move the low byte
    sequence idle0;
        !run_bit_zero && !wr_low_zero && !wr_high_zero;
    endsequence
    sequence frozen1;
        timer_mode_reg[5:4] == 2'h3 && !wr_low_one && !wr_high_one;
    endsequence
    chk_idle_hold: assert property (idle0 [*3] |-> $stable(count_low_byte_zero))
        else $error("low byte moved while stopped");
    chk_t1_frozen: assert property (frozen1 [*3] |-> $stable(count_low_byte_one)
        && $stable(count_high_byte_one)) else $error("timer one moved in mode three");
    chk_write_low: assert property (wr_low_zero |=> count_low_byte_zero == $past(wr_data))
        else $error("low byte write lost");
    chk_write_one: assert property (wr_high_one |=> count_high_byte_one == $past(wr_data))
        else $error("high byte one write lost");
    chk_flag_hold: assert property ($fell(overflow_flag_zero) |-> $past(ovf_clr_zero))
        else $error("flag zero dropped without clear");
    chk_flag1_hold: assert property ($fell(overflow_flag_one) |-> $past(ovf_clr_one))
        else $error("flag one dropped without clear");
    // Writes excluded: they may land between ticks
    chk_rate_six: assert property (($changed(count_low_byte_zero) && !$past(wr_low_zero)) |=>
        (!$changed(count_low_byte_zero) || $past(wr_low_zero)) [*5])
        else $error("low byte counted faster than machine cycle");
    chk_reload_eight: assert property (($past(timer_mode_reg[1:0]) == 2'h2 &&
        $past(count_low_byte_zero) == 8'hFF && $changed(count_low_byte_zero) &&
        !$past(wr_low_zero) && !$past(wr_high_zero)) |->
        count_low_byte_zero == count_high_byte_zero && overflow_flag_zero)
        else $error("reload or flag wrong");
    chk_carry_five: assert property (($past(timer_mode_reg[1:0]) == 2'h0 &&
        $changed(count_high_byte_zero) && !$past(wr_high_zero) && !$past(wr_low_zero))
        |-> count_low_byte_zero[4:0] == 5'h00) else $error("13-bit carry wrong");
    chk_oe_follow: assert property ($rose(toggle_out_enable) |=> count_in_pin_zero_oe)
        else $error("toggle drive not enabled");
endmodule
bind dtc_top dtc_properties i_dtc_properties (.mclk, .rst, .timer_mode_reg, .run_bit_zero,
    .ovf_clr_zero, .ovf_clr_one, .toggle_out_enable, .wr_high_zero, .wr_low_zero,
    .wr_high_one, .wr_low_one, .wr_data, .count_high_byte_zero, .count_low_byte_zero,
    .count_high_byte_one, .count_low_byte_one, .overflow_flag_zero, .overflow_flag_one,
    .count_in_pin_zero_oe);

// ### verification/tb.sv
// Self-checking bench for the dual timer unit
`timescale 1ns/1ps
module tb;
    import dtc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] tmode = 8'h00;
    logic run0 = 1'b0, run1 = 1'b0, clr0 = 1'b0, clr1 = 1'b0, ten = 1'b0;
    logic [3:0] wr = 4'h0;
    dtc_byte_t wdat = 8'h00;
    dtc_byte_t cnt [4];
    logic f0, f1, po, poe, pin, gate;
    int err_count = 0;
    int checked = 0;
    dtc_top i_dtc_top (.mclk, .rst, .timer_mode_reg(tmode), .run_bit_zero(run0),
        .run_bit_one(run1), .ovf_clr_zero(clr0), .ovf_clr_one(clr1), .toggle_out_enable(ten),
        .ext_irq_zero_pin(gate), .count_in_pin_zero_i(pin), .wr_high_zero(wr[0]),
        .wr_low_zero(wr[1]), .wr_high_one(wr[2]), .wr_low_one(wr[3]), .wr_data(wdat),
        .count_high_byte_zero(cnt[0]), .count_low_byte_zero(cnt[1]),
        .count_high_byte_one(cnt[2]), .count_low_byte_one(cnt[3]), .overflow_flag_zero(f0),
        .overflow_flag_one(f1), .count_in_pin_zero_o(po), .count_in_pin_zero_oe(poe));
    dtc_pin_src i_dtc_pin_src (.mclk, .pin_o(po), .pin_oe(poe), .pin_lvl(pin), .gate(gate));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobe index: 0 high0, 1 low0, 2 high1, 3 low1
    task automatic wr_byte(input int sel, input dtc_byte_t d);
        @(negedge mclk);
        wr[sel] = 1'b1;
        wdat = d;
        @(negedge mclk);
        wr = 4'h0;
    endtask
    task automatic wait_flag(input int sel, output int n);
        n = 0;
        while ((sel ? f1 : f0) !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial forever #5 mclk = ~mclk;
    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        int n;
        dtc_byte_t old;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        chk("reset low0", cnt[1], 8'h00);
        chk("reset pin", {poe, po}, 8'h01);
        $display("test reset done");
        for (int m = 0; m < 3; m++) begin
            tmode = 8'(m);
            wr_byte(0, m == 2 ? 8'hF0 : 8'hFF);
            wr_byte(1, 8'hFE);
            run0 = 1'b1;
            old = cnt[1];
            n = 0;
            while (cnt[1] === old && n < 20) begin
                @(negedge mclk);
                n++;
            end
            wait_flag(0, n);
            chk("ovf gap", 8'(n), 8'h06);
            chk("ovf high0", cnt[0], m == 2 ? 8'hF0 : 8'h00);
            // Upper three low-byte bits are undefined in mode zero
            chk("ovf low0", cnt[1] & (m == 0 ? 8'h1F : 8'hFF), m == 2 ? 8'hF0 : 8'h00);
            run0 = 1'b0;
            clr0 = 1'b1;
            @(negedge mclk);
            clr0 = 1'b0;
            @(negedge mclk);
            chk("flag0 clear", f0, 8'h00);
        end
        $display("test modes done");
        tmode = 8'h09;
        wr_byte(1, 8'h00);
        run0 = 1'b1;
        repeat (20) @(negedge mclk);
        chk("gated low0", cnt[1], 8'h00);
        i_dtc_pin_src.set_gate(1'b1);
        repeat (20) @(negedge mclk);
        chk("gate open", cnt[1] != 8'h00, 8'h01);
        run0 = 1'b0;
        tmode = 8'h05;
        wr_byte(1, 8'h00);
        run0 = 1'b1;
        i_dtc_pin_src.falls(3);
        repeat (12) @(negedge mclk);
        chk("events low0", cnt[1], 8'h03);
        $display("test gate and events done");
        run0 = 1'b0;
        tmode = 8'h03;
        wr_byte(1, 8'h10);
        wr_byte(0, 8'hFE);
        run1 = 1'b1;
        wait_flag(1, n);
        chk("split flag1", {f0, f1}, 8'h01);
        chk("split low0", cnt[1], 8'h10);
        chk("split high0", cnt[0], 8'h00);
        chk("t1 running", cnt[3] != 8'h00, 8'h01);
        tmode = 8'h33;
        repeat (2) @(negedge mclk);
        old = cnt[3];
        repeat (20) @(negedge mclk);
        chk("t1 halted", cnt[3], old);
        run1 = 1'b0;
        clr1 = 1'b1;
        @(negedge mclk);
        clr1 = 1'b0;
        @(negedge mclk);
        chk("flag1 clear", f1, 8'h00);
        $display("test split done");
        tmode = 8'h10;
        wr_byte(2, 8'hFF);
        wr_byte(3, 8'hFE);
        chk("write high1", cnt[2], 8'hFF);
        chk("write low1", cnt[3], 8'hFE);
        run1 = 1'b1;
        wait_flag(1, n);
        chk("t1 ovf flag", f1, 8'h01);
        chk("t1 ovf high", cnt[2], 8'h00);
        chk("t1 ovf low", cnt[3], 8'h00);
        run1 = 1'b0;
        clr1 = 1'b1;
        @(negedge mclk);
        clr1 = 1'b0;
        @(negedge mclk);
        chk("flag1 clear t1", f1, 8'h00);
        $display("test timer one done");
        tmode = 8'h01;
        ten = 1'b1;
        repeat (2) @(negedge mclk);
        chk("toggle start", {poe, po}, 8'h03);
        wr_byte(0, 8'hFF);
        wr_byte(1, 8'hFF);
        run0 = 1'b1;
        wait_flag(0, n);
        repeat (2) @(negedge mclk);
        chk("toggle flip", po, 8'h00);
        $display("test toggle done");
        results();
    end
endmodule
